// ### src/spm_sfr_map.v
// SFR map select, port page decode and paged port configuration registers
//
// Notes on behaviour
// [R1] Bit 0 of the system control register picks the standard area when clear and the mapped area when set.
// [R2] Bit 2 of the system control register always reads as one whatever is written.
// [R3] Bits 7 to 5, 3 and 1 of the system control register always read as zero.
// [R4] The system control register resets to 04 hex, so the standard area is selected.
// [R5] Software changes the map bit by read-modify-write and leaves the other bits alone.
// [R6] The 8-bit address plus the map bit give 512 locations, 256 in each area.
// [R7] Paged registers are decoded from the page field as well as the SFR address.
// [R8] Software writes the page field before touching a paged register.
// [R9] Page count and registers per page are set per module by parameters.
// [R10] A paged register answers only when both the map bit and the page field match its own values.
// [R11] In the standard area on page 3 the open-drain registers hold 8 read-write bits reset to 00.
// [R12] On that page the drive-strength registers hold 8 read-write bits reset to FF.
// [R13] The alternate-select registers hold 8 read-write bits each, reset to 00.
// [R14] An address with no register behind it reads zero and ignores writes without side effects.
// [R15] A write to the map bit or page field governs the very next access with no wait.
`timescale 1ns/1ns
`default_nettype none

`include "spm_regs.vh"

module spm_sfr_map (
  // Clock and reset
  input  wire       i_mclk,
  input  wire       i_rst_n,
  // SFR access from the CPU core
  input  wire [7:0] i_sfr_addr,
  input  wire       i_sfr_wr,
  input  wire       i_sfr_rd,
  input  wire [7:0] i_sfr_wdata,
  output reg  [7:0] o_sfr_rdata,
  // System control state
  output wire       o_sfr_map_select,
  output wire       o_interrupt_structure_select,
  output wire [2:0] o_module_page_select,
  // Alternate-function selects
  output wire [7:0] o_port1_alt_select_1,
  output wire [7:0] o_port5_alt_select_0,
  output wire [7:0] o_port5_alt_select_1,
  output wire [7:0] o_port3_alt_select_0,
  output wire [7:0] o_port3_alt_select_1,
  output wire [7:0] o_port4_alt_select_0,
  output wire [7:0] o_port4_alt_select_1,
  // Open-drain controls
  output wire [7:0] o_port0_open_drain,
  output wire [7:0] o_port1_open_drain,
  output wire [7:0] o_port5_open_drain,
  output wire [7:0] o_port3_open_drain,
  output wire [7:0] o_port4_open_drain,
  // Drive-strength controls
  output wire [7:0] o_port0_drive_strength,
  output wire [7:0] o_port1_drive_strength,
  output wire [7:0] o_port5_drive_strength,
  output wire [7:0] o_port3_drive_strength,
  output wire [7:0] o_port4_drive_strength
);

  // Cell table, cell 0 in the low byte of each vector
  localparam integer NCELL = `SPM_NUM_CELLS;

  localparam [NCELL*8-1:0] CELL_ADDR = {
    `SPM_PORT4_DRIVE_STRENGTH_ADDR,   `SPM_PORT4_OPEN_DRAIN_ADDR,
    `SPM_PORT3_DRIVE_STRENGTH_ADDR,   `SPM_PORT3_OPEN_DRAIN_ADDR,
    `SPM_PORT5_DRIVE_STRENGTH_ADDR,   `SPM_PORT5_OPEN_DRAIN_ADDR,
    `SPM_PORT1_DRIVE_STRENGTH_ADDR,   `SPM_PORT1_OPEN_DRAIN_ADDR,
    `SPM_PORT0_DRIVE_STRENGTH_ADDR,   `SPM_PORT0_OPEN_DRAIN_ADDR,
    `SPM_P4_ALT1_ADDR, `SPM_P4_ALT0_ADDR,
    `SPM_P3_ALT1_ADDR, `SPM_P3_ALT0_ADDR,
    `SPM_P5_ALT1_ADDR, `SPM_P5_ALT0_ADDR,
    `SPM_P1_ALT1_ADDR
  };

  // Page of each cell, same order
  localparam [NCELL*3-1:0] CELL_PAGE = {
    {10{`SPM_PAGE_PAD}},
    {7{`SPM_PAGE_ALT}}
  };

  // Reset value of each cell, same order
  localparam [NCELL*8-1:0] CELL_RESET = {
    `SPM_DS_RESET,  `SPM_OD_RESET,
    `SPM_DS_RESET,  `SPM_OD_RESET,
    `SPM_DS_RESET,  `SPM_OD_RESET,
    `SPM_DS_RESET,  `SPM_OD_RESET,
    `SPM_DS_RESET,  `SPM_OD_RESET,
    {7{`SPM_ALT_RESET}}
  };

  // Reset image of the system control register, so the map bit is picked by position
  localparam [7:0] SYSCTL_RST = `SPM_SYSCTL0_RESET;

  // Synchronised reset
  reg                 rst_meta_q;
  reg                 rst_sync_q;
  wire                rst_n;

  // Control state
  reg                 map_q;
  reg                 interrupt_structure_select_q;
  reg  [2:0]          page_q;

  // Cell wiring
  wire [NCELL-1:0]    cell_hit;
  wire [NCELL*8-1:0]  cell_q;

  // Decoding of the unpaged registers
  wire                sysctl_hit;
  wire                page_hit;
  wire [7:0]          sysctl_view;

  // Read path
  reg  [7:0]          rdata_d;
  integer             k;

  // Reset release through two flip-flops, assertion stays asynchronous
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_n = rst_sync_q;

  // System control register seen in both areas, page register only in the standard area
  assign sysctl_hit = (i_sfr_addr == `SPM_SYSCTL0_ADDR); // [R6]
  assign page_hit   = (i_sfr_addr == `SPM_PAGE_ADDR) && !map_q; // [R1]

  // Reserved bits are constants, only two bits are stored
  assign sysctl_view = `SPM_SYSCTL0_ONES // [R2]
                     | ({7'h00, map_q} << `SPM_MAP_SELECT_BIT) // [R3]
                     | ({7'h00, interrupt_structure_select_q} << `SPM_INT_STRUCT_BIT);

  // Map select and interrupt structure bits; other written bits are dropped
  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      map_q   <= SYSCTL_RST[`SPM_MAP_SELECT_BIT]; // [R4]
      interrupt_structure_select_q <= 1'b0;
    end else if (i_sfr_wr && sysctl_hit) begin
      map_q   <= i_sfr_wdata[`SPM_MAP_SELECT_BIT]; // [R1] [R15]
      interrupt_structure_select_q <= i_sfr_wdata[`SPM_INT_STRUCT_BIT];
    end
  end

  // Page field; new value steers the decode from the next cycle on
  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      page_q <= `SPM_PAGE_RESET;
    end else if (i_sfr_wr && page_hit) begin
      page_q <= i_sfr_wdata[`SPM_PAGE_WIDTH-1:0]; // [R8] [R15]
    end
  end

  // One cell per paged register; table above sets address, page and reset
  genvar g;
  generate
    for (g = 0; g < NCELL; g = g + 1) begin : g_cell
      spm_page_cell #(
        .ADDR  (CELL_ADDR[g*8 +: 8]),
        .PAGE  (CELL_PAGE[g*3 +: 3]),
        .RESET (CELL_RESET[g*8 +: 8])
      ) u_cell (
        .i_clk   (i_mclk),
        .i_rst_n (rst_n),
        .i_addr  (i_sfr_addr),
        .i_page  (page_q),
        .i_map   (map_q),
        .i_wr    (i_sfr_wr),
        .i_wdata (i_sfr_wdata),
        .o_hit   (cell_hit[g]),
        .o_q     (cell_q[g*8 +: 8])
      ); // [R9] [R10] [R11] [R12] [R13]
    end
  endgenerate

  // Read mux; decodes are exclusive, so OR-ing is safe and misses give zero
  always @* begin
    rdata_d = 8'h00; // [R14]
    if (sysctl_hit) begin
      rdata_d = sysctl_view;
    end
    if (page_hit) begin
      rdata_d = rdata_d | ({5'h00, page_q} & `SPM_PAGE_MASK);
    end
    for (k = 0; k < NCELL; k = k + 1) begin
      if (cell_hit[k]) begin
        rdata_d = rdata_d | cell_q[k*8 +: 8]; // [R7]
      end
    end
  end

  // Read data registered, held between reads; reads have no side effects
  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_sfr_rd) begin
      o_sfr_rdata <= rdata_d;
    end
  end

  // Control state outputs, each from its flip-flop
  assign o_sfr_map_select             = map_q;
  assign o_interrupt_structure_select = interrupt_structure_select_q;
  assign o_module_page_select         = page_q;

  // Alternate-select outputs
  assign o_port1_alt_select_1 = cell_q[0*8 +: 8];
  assign o_port5_alt_select_0 = cell_q[1*8 +: 8];
  assign o_port5_alt_select_1 = cell_q[2*8 +: 8];
  assign o_port3_alt_select_0 = cell_q[3*8 +: 8];
  assign o_port3_alt_select_1 = cell_q[4*8 +: 8];
  assign o_port4_alt_select_0 = cell_q[5*8 +: 8];
  assign o_port4_alt_select_1 = cell_q[6*8 +: 8];

  // Pad control outputs
  assign o_port0_open_drain     = cell_q[7*8 +: 8];
  assign o_port0_drive_strength = cell_q[8*8 +: 8];
  assign o_port1_open_drain     = cell_q[9*8 +: 8];
  assign o_port1_drive_strength = cell_q[10*8 +: 8];
  assign o_port5_open_drain     = cell_q[11*8 +: 8];
  assign o_port5_drive_strength = cell_q[12*8 +: 8];
  assign o_port3_open_drain     = cell_q[13*8 +: 8];
  assign o_port3_drive_strength = cell_q[14*8 +: 8];
  assign o_port4_open_drain     = cell_q[15*8 +: 8];
  assign o_port4_drive_strength = cell_q[16*8 +: 8];

endmodule // spm_sfr_map

`default_nettype wire

// ### src/spm_regs.vh
// Register offsets, page codes, field positions and reset values of the SFR map and page extension
`ifndef SPM_REGS_VH
`define SPM_REGS_VH

// System control register 0, present in both SFR areas
`define SPM_SYSCTL0_ADDR        8'hBF
`define SPM_SYSCTL0_RESET       8'h04
`define SPM_SYSCTL0_ONES        8'h04
`define SPM_SYSCTL0_RW_MASK     8'h11
`define SPM_MAP_SELECT_BIT      0
`define SPM_INT_STRUCT_BIT      4

// Port module page-select register, standard area only
`define SPM_PAGE_ADDR           8'hB2
`define SPM_PAGE_WIDTH          3
`define SPM_PAGE_MASK           8'h07
`define SPM_PAGE_RESET          3'h0

// Pages of the port module
`define SPM_PAGE_ALT            3'h2
`define SPM_PAGE_PAD            3'h3

// Alternate-function select registers
`define SPM_P1_ALT1_ADDR        8'h91
`define SPM_P5_ALT0_ADDR        8'h92
`define SPM_P5_ALT1_ADDR        8'h93
`define SPM_P3_ALT0_ADDR        8'hB0
`define SPM_P3_ALT1_ADDR        8'hB1
`define SPM_P4_ALT0_ADDR        8'hC8
`define SPM_P4_ALT1_ADDR        8'hC9
`define SPM_ALT_RESET           8'h00

// Open-drain and drive-strength registers
`define SPM_PORT0_OPEN_DRAIN_ADDR          8'h80
`define SPM_PORT0_DRIVE_STRENGTH_ADDR          8'h86
`define SPM_PORT1_OPEN_DRAIN_ADDR          8'h90
`define SPM_PORT1_DRIVE_STRENGTH_ADDR          8'h91
`define SPM_PORT5_OPEN_DRAIN_ADDR          8'h92
`define SPM_PORT5_DRIVE_STRENGTH_ADDR          8'h93
`define SPM_PORT3_OPEN_DRAIN_ADDR          8'hB0
`define SPM_PORT3_DRIVE_STRENGTH_ADDR          8'hB1
`define SPM_PORT4_OPEN_DRAIN_ADDR          8'hC8
`define SPM_PORT4_DRIVE_STRENGTH_ADDR          8'hC9
`define SPM_OD_RESET            8'h00
`define SPM_DS_RESET            8'hFF

// Number of paged cells
`define SPM_NUM_CELLS           17

`endif

// ### src/spm_page_cell.v
// One paged 8-bit read-write SFR, decoded from map select, page field and address
`timescale 1ns/1ns
`default_nettype none

module spm_page_cell #(
  parameter [7:0] ADDR  = 8'h00,
  parameter [2:0] PAGE  = 3'h0,
  parameter [7:0] RESET = 8'h00
) (
  // Clock and reset
  input  wire       i_clk,
  input  wire       i_rst_n,
  // Decode inputs
  input  wire [7:0] i_addr,
  input  wire [2:0] i_page,
  input  wire       i_map,
  input  wire       i_wr,
  input  wire [7:0] i_wdata,
  // Register state
  output wire       o_hit,
  output reg  [7:0] o_q
);

  // Hit needs standard area, own page and own address together
  assign o_hit = (i_map == 1'b0) && (i_page == PAGE) && (i_addr == ADDR); // [R7] [R10]

  // Storage, writes only on a full match
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_q <= RESET;
    end else if (i_wr && o_hit) begin
      o_q <= i_wdata;
    end
  end

endmodule // spm_page_cell

`default_nettype wire

// ### test/spm_sfr_map_properties.sv
// Concurrent checks on the SFR map and port page decode
`timescale 1ns/1ns
`default_nettype none

module spm_sfr_map_chk (
  // Clock, reset and access
  input wire logic       i_mclk,
  input wire logic       i_rst_n,
  input wire logic [7:0] i_sfr_addr,
  input wire logic       i_sfr_wr,
  input wire logic       i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  // Watched outputs
  input wire logic [7:0] o_sfr_rdata,
  input wire logic       o_sfr_map_select,
  input wire logic       o_interrupt_structure_select,
  input wire logic [2:0] o_module_page_select,
  input wire logic [7:0] o_port0_open_drain,
  input wire logic [7:0] o_port1_alt_select_1
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // Paged hits need map clear and the cell's own page
  wire logic od_hit  = !o_sfr_map_select && o_module_page_select == 3'h3 && i_sfr_addr == 8'h80;
  wire logic alt_hit = !o_sfr_map_select && o_module_page_select == 3'h2 && i_sfr_addr == 8'h91;

  chk_rd_holds: assert property (!i_sfr_rd |=> $stable(o_sfr_rdata)) else $error("rdata moved");
  chk_sys_read: assert property (i_sfr_rd && i_sfr_addr == 8'hBF |=> o_sfr_rdata ==
    {3'h0, $past(o_interrupt_structure_select), 3'h2, $past(o_sfr_map_select)}) else $error("sysctl read");
  chk_map_wr: assert property (i_sfr_wr && i_sfr_addr == 8'hBF |=>
    {7'h00, o_sfr_map_select} == ($past(i_sfr_wdata) & 8'h01)) else $error("map bit");
  chk_page_wr: assert property (i_sfr_wr && i_sfr_addr == 8'hB2 && !o_sfr_map_select |=>
    {5'h00, o_module_page_select} == ($past(i_sfr_wdata) & 8'h07)) else $error("page write");
  chk_page_lock: assert property (i_sfr_wr && i_sfr_addr == 8'hB2 && o_sfr_map_select
    |=> $stable(o_module_page_select)) else $error("page written while mapped");
  chk_od_wr: assert property (i_sfr_wr && od_hit |=> o_port0_open_drain == $past(i_sfr_wdata))
    else $error("open drain write");
  chk_od_keep: assert property (!(i_sfr_wr && od_hit) |=> $stable(o_port0_open_drain))
    else $error("open drain changed");
  chk_alt_wr: assert property (i_sfr_wr && alt_hit |=> o_port1_alt_select_1 == $past(i_sfr_wdata))
    else $error("alt select write");
  chk_mapped_rd: assert property (i_sfr_rd && o_sfr_map_select && i_sfr_addr == 8'h80
    |=> o_sfr_rdata == 8'h00) else $error("mapped paged read");
endmodule // spm_sfr_map_chk

bind spm_sfr_map spm_sfr_map_chk i_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sfr_addr(i_sfr_addr),
  .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata),
  .o_sfr_map_select(o_sfr_map_select), .o_interrupt_structure_select(o_interrupt_structure_select),
  .o_module_page_select(o_module_page_select), .o_port0_open_drain(o_port0_open_drain),
  .o_port1_alt_select_1(o_port1_alt_select_1));

`default_nettype wire

// ### test/spm_cpu_model.sv
// CPU core model issuing SFR reads and writes
`timescale 1ns/1ns
`default_nettype none

module spm_cpu_model (
  // Clock and read data
  input  wire logic       i_mclk,
  input  wire logic [7:0] i_rdata,
  // SFR access
  output var  logic [7:0] o_addr,
  output var  logic       o_wr,
  output var  logic       o_rd,
  output var  logic [7:0] o_wdata
);
  // Quiet bus until the first access
  initial begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
  end

  // Entered at a falling edge; strobe stays up so calls run back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    o_rd = 1'b0;
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_mclk);
  endtask

  // Data lands on the rising edge inside the cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    o_wr = 1'b0;
    o_wdata = ~o_wdata;
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_mclk);
    d = i_rdata;
  endtask

  // Map bit changed only by and/or on a fresh read
  task automatic rmw(input logic [7:0] a, input logic [7:0] m_and, input logic [7:0] m_or);
    logic [7:0] v;
    rd(a, v);
    wr(a, (v & m_and) | m_or);
  endtask

  task automatic idle();
    o_wr = 1'b0;
    o_rd = 1'b0;
    @(negedge i_mclk);
  endtask
endmodule // spm_cpu_model

`default_nettype wire

// ### test/spm_sfr_map_tb.sv
// Self-checking bench for the SFR map and port page registers
`timescale 1ns/1ns
`default_nettype none

module spm_sfr_map_tb;
  logic       clk;
  logic       rst_n;
  logic [7:0] addr, wdata, rdata, d;
  logic [7:0] pins [17];
  logic       wr, rd, map, interrupt_structure_select;
  logic [2:0] page;
  int         errors, n_compared, i;
  // Address, page and reset value of each paged cell
  logic [18:0] rows [17] = '{{8'h91, 3'h2, 8'h00}, {8'h92, 3'h2, 8'h00}, {8'h93, 3'h2, 8'h00},
    {8'hB0, 3'h2, 8'h00}, {8'hB1, 3'h2, 8'h00}, {8'hC8, 3'h2, 8'h00}, {8'hC9, 3'h2, 8'h00},
    {8'h80, 3'h3, 8'h00}, {8'h86, 3'h3, 8'hFF}, {8'h90, 3'h3, 8'h00}, {8'h91, 3'h3, 8'hFF},
    {8'h92, 3'h3, 8'h00}, {8'h93, 3'h3, 8'hFF}, {8'hB0, 3'h3, 8'h00}, {8'hB1, 3'h3, 8'hFF},
    {8'hC8, 3'h3, 8'h00}, {8'hC9, 3'h3, 8'hFF}};

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  spm_cpu_model i_cpu (.i_mclk(clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));

  spm_sfr_map i_dut (.i_mclk(clk), .i_rst_n(rst_n), .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_rd(rd),
    .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .o_sfr_map_select(map), .o_interrupt_structure_select(interrupt_structure_select),
    .o_module_page_select(page), .o_port1_alt_select_1(pins[0]), .o_port5_alt_select_0(pins[1]),
    .o_port5_alt_select_1(pins[2]), .o_port3_alt_select_0(pins[3]), .o_port3_alt_select_1(pins[4]),
    .o_port4_alt_select_0(pins[5]), .o_port4_alt_select_1(pins[6]), .o_port0_open_drain(pins[7]),
    .o_port0_drive_strength(pins[8]), .o_port1_open_drain(pins[9]), .o_port1_drive_strength(pins[10]),
    .o_port5_open_drain(pins[11]), .o_port5_drive_strength(pins[12]), .o_port3_open_drain(pins[13]),
    .o_port3_drive_strength(pins[14]), .o_port4_open_drain(pins[15]), .o_port4_drive_strength(pins[16]));

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      errors++;
    end
  endtask

  task automatic close_out();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard
  initial begin
    #100000;
    errors++;
    close_out();
  end

  initial begin
    errors = 0;
    n_compared = 0;
    rst_n = 1'b0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    i_cpu.rd(8'hBF, d); chk("sysctl reset", 8'h04, d);
    // Reset value of each cell, then a distinct pattern; page 2 and 3 share addresses
    for (i = 0; i < 17; i++) begin
      i_cpu.wr(8'hB2, {5'h00, rows[i][10:8]});
      i_cpu.rd(rows[i][18:11], d); chk("reset value", rows[i][7:0], d);
      i_cpu.wr(rows[i][18:11], 8'h30 + i[7:0]);
    end
    for (i = 0; i < 17; i++) begin
      i_cpu.wr(8'hB2, {5'h00, rows[i][10:8]});
      i_cpu.rd(rows[i][18:11], d); chk("readback", 8'h30 + i[7:0], d);
    end
    // Every configuration output carries its own written pattern
    for (i = 0; i < 17; i++) begin
      chk("config output", 8'h30 + i[7:0], pins[i]);
    end
    // Reserved bits and mapped area
    i_cpu.wr(8'hBF, 8'hFF);
    i_cpu.rd(8'hBF, d); chk("sysctl fixed bits", 8'h15, d);
    chk("map bit", 8'h01, {7'h00, map});
    i_cpu.wr(8'h80, 8'hEE);
    i_cpu.rd(8'h80, d); chk("mapped paged read", 8'h00, d);
    i_cpu.rd(8'hB2, d); chk("mapped page read", 8'h00, d);
    i_cpu.rmw(8'hBF, 8'hFE, 8'h00);
    i_cpu.rd(8'h80, d); chk("od0 after unmap", 8'h37, d);
    chk("interrupt_structure_select kept", 8'h01, {7'h00, interrupt_structure_select});
    i_cpu.rd(8'hA0, d); chk("unmapped read", 8'h00, d);
    // Reset in mid-run
    i_cpu.idle();
    rst_n = 1'b0;
    @(negedge clk);
    chk("ds0 in reset", 8'hFF, pins[8]);
    chk("od0 in reset", 8'h00, pins[7]);
    chk("page in reset", 8'h00, {5'h00, page});
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    i_cpu.rd(8'hBF, d); chk("sysctl second reset", 8'h04, d);
    close_out();
  end
endmodule // spm_sfr_map_tb

`default_nettype wire
